// ===== hw/pwmcfg_params.svh
// constants of the pwm engine configuration block: codes, fields, defaults
`ifndef PWMCFG_PARAMS_SVH
`define PWMCFG_PARAMS_SVH

// command codes
`define PWMCFG_CMD_COMMANDED_RESET    8'hFD
`define PWMCFG_CMD_PWM_MODE           8'hD4
`define PWMCFG_CMD_PHASE_SHARE_CFG    8'hF5
`define PWMCFG_CMD_SWITCH_FREQ        8'h33

// reset values
`define PWMCFG_PWM_MODE_RESET         8'hC1
`define PWMCFG_PHASE_CFG_RESET        8'h10
`define PWMCFG_SWITCH_FREQ_RESET      16'hFABC

// pwm mode byte fields
`define PWMCFG_MODE_CONTINUOUS_BIT    0
`define PWMCFG_MODE_VRANGE_LOW_BIT    1
`define PWMCFG_MODE_SERVO_BIT         6
`define PWMCFG_MODE_IRANGE_HIGH_BIT   7

// phase and share config byte fields
`define PWMCFG_CFG_PHASE_MSB          2
`define PWMCFG_CFG_PHASE_LSB          0
`define PWMCFG_CFG_SHARE_CLK_EN_BIT   4
`define PWMCFG_CFG_EA_COUPLE_BIT      7
`define PWMCFG_PHASE_CODE_UNDEFINED   3'h7

// exp5_mant11_format fields
`define PWMCFG_LIN_EXP_MSB            15
`define PWMCFG_LIN_EXP_LSB            11
`define PWMCFG_LIN_MANT_MSB           10

// supported switching frequencies, kHz; zero stands for external oscillator
`define PWMCFG_FREQ_EXTERNAL          16'h0000
`define PWMCFG_FREQ_250               16'd250
`define PWMCFG_FREQ_350               16'd350
`define PWMCFG_FREQ_425               16'd425
`define PWMCFG_FREQ_500               16'd500
`define PWMCFG_FREQ_575               16'd575
`define PWMCFG_FREQ_650               16'd650
`define PWMCFG_FREQ_750               16'd750
`define PWMCFG_FREQ_1000              16'd1000

`endif

// ===== hw/pwmcfg_pkg.sv
// types shared by the pwm engine configuration block
package pwmcfg_pkg;

  typedef logic [7:0]  pwmcfg_byte_t;
  typedef logic [15:0] pwmcfg_word_t;
  typedef logic [8:0]  pwmcfg_deg_t;

  // outcome of one host command
  typedef enum logic [1:0] {
    PWMCFG_RESP_OK,
    PWMCFG_RESP_BUSY,
    PWMCFG_RESP_UNSUPPORTED
  } pwmcfg_resp_t;

endpackage

// ===== hw/pwmcfg_phase_decode.sv
// phase selection code to per-channel phase offsets in degrees
`timescale 1ns/1ps
module pwmcfg_phase_decode (
  // selection
  input  wire logic [2:0]               i_code,
  // offsets after the sync falling edge
  output pwmcfg_pkg::pwmcfg_deg_t       o_phase0_deg,
  output pwmcfg_pkg::pwmcfg_deg_t       o_phase1_deg,
  output logic                          o_valid
);
  import pwmcfg_pkg::*;

  always_comb begin
    o_valid      = 1'b1;
    o_phase0_deg = 9'd0;
    o_phase1_deg = 9'd180;
    unique case (i_code)
      3'b000: begin
        o_phase0_deg = 9'd0;
        o_phase1_deg = 9'd180;
      end
      3'b001: begin
        o_phase0_deg = 9'd90;
        o_phase1_deg = 9'd270;
      end
      3'b010: begin
        o_phase0_deg = 9'd0;
        o_phase1_deg = 9'd240;
      end
      3'b011: begin
        o_phase0_deg = 9'd0;
        o_phase1_deg = 9'd120;
      end
      3'b100: begin
        o_phase0_deg = 9'd120;
        o_phase1_deg = 9'd240;
      end
      3'b101: begin
        o_phase0_deg = 9'd60;
        o_phase1_deg = 9'd240;
      end
      3'b110: begin
        o_phase0_deg = 9'd120;
        o_phase1_deg = 9'd300;
      end
      3'b111: begin
        // undefined code, never stored
        o_valid = 1'b0;
      end
    endcase
  end

endmodule // pwmcfg_phase_decode

// ===== hw/pwmcfg_top.sv
// pwm engine configuration commands: reset, mode, phase/share, frequency
`timescale 1ns/1ps
`include "pwmcfg_params.svh"

module pwmcfg_top (
  // clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_reset_n,
  // host command port
  input  wire logic                     i_cmd_valid,
  input  wire logic                     i_cmd_write,
  input  wire logic [7:0]               i_cmd_code,
  input  wire logic                     i_cmd_page,
  input  wire pwmcfg_pkg::pwmcfg_word_t i_cmd_wdata,
  output logic                          o_cmd_done,
  output pwmcfg_pkg::pwmcfg_resp_t      o_cmd_resp,
  output pwmcfg_pkg::pwmcfg_word_t      o_cmd_rdata,
  output logic                          o_busy_fault,
  output logic                          o_commanded_reset,
  // channel state
  input  wire logic [1:0]               i_run,
  input  wire logic [1:0]               i_commanded_on,
  input  wire logic [1:0]               i_ramping_on,
  input  wire logic [1:0]               i_ramping_off,
  // input supply comparators
  input  wire logic                     i_vin_above_turn_on,
  input  wire logic                     i_vin_below_turn_off,
  // shared sync signal
  input  wire logic                     i_sync,
  // pwm engine controls
  output logic [1:0]                    o_forced_continuous,
  output logic [1:0]                    o_current_range_high,
  output logic [1:0]                    o_voltage_range_low,
  output logic [1:0]                    o_servo_active,
  output logic                          o_ea_coupled,
  output pwmcfg_pkg::pwmcfg_deg_t       o_phase0_deg,
  output pwmcfg_pkg::pwmcfg_deg_t       o_phase1_deg,
  output logic                          o_sync_fall,
  output pwmcfg_pkg::pwmcfg_word_t      o_switch_freq_khz,
  output logic                          o_external_osc,
  output logic                          o_pll_relock,
  // share clock pin, open drain
  output logic                          o_share_clk_out,
  output logic                          o_share_clk_oe
);
  import pwmcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // exp5_mant11_format to an integer, clipped to 0..65535
  function automatic pwmcfg_word_t lin11_value(input pwmcfg_word_t w);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    logic signed [31:0] v;
    logic [4:0]         sh;
    e  = w[`PWMCFG_LIN_EXP_MSB:`PWMCFG_LIN_EXP_LSB];
    m  = 32'(signed'(w[`PWMCFG_LIN_MANT_MSB:0]));
    sh = 5'(-e);
    if (e < 0)
      v = m >>> sh;
    else
      v = m <<< e[3:0];
    if (v < 0)
      lin11_value = 16'h0000;
    else if (v > 32'sd65535)
      lin11_value = 16'hFFFF;
    else
      lin11_value = v[15:0];
  endfunction

  function automatic logic freq_supported(input pwmcfg_word_t khz);
    freq_supported = (khz == `PWMCFG_FREQ_EXTERNAL) ||
                     (khz == `PWMCFG_FREQ_250) || (khz == `PWMCFG_FREQ_350) ||
                     (khz == `PWMCFG_FREQ_425) || (khz == `PWMCFG_FREQ_500) ||
                     (khz == `PWMCFG_FREQ_575) || (khz == `PWMCFG_FREQ_650) ||
                     (khz == `PWMCFG_FREQ_750) || (khz == `PWMCFG_FREQ_1000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       soft_rst_reg;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic         chan_running [2];
  logic         device_off;
  logic         hit_reset;
  logic         hit_mode;
  logic         hit_cfg;
  logic         hit_freq;
  logic         wr;
  logic         rd;
  logic         cfg_code_ok;
  logic [15:0]  freq_khz_new;
  logic         freq_ok;
  logic         cfg_accept;
  logic         freq_accept;
  logic         mode_accept;
  logic         busy_refuse;
  logic         bad_cmd;
  pwmcfg_resp_t resp_next;
  pwmcfg_word_t rdata_next;

  pwmcfg_byte_t mode_reg [2];
  pwmcfg_byte_t cfg_reg;
  pwmcfg_word_t freq_reg;

  // off means every channel has run low or is commanded off
  assign chan_running[0] = i_run[0] & i_commanded_on[0];
  assign chan_running[1] = i_run[1] & i_commanded_on[1];
  assign device_off      = !(chan_running[0] || chan_running[1]);

  assign hit_reset = (i_cmd_code == `PWMCFG_CMD_COMMANDED_RESET);
  assign hit_mode  = (i_cmd_code == `PWMCFG_CMD_PWM_MODE);
  assign hit_cfg   = (i_cmd_code == `PWMCFG_CMD_PHASE_SHARE_CFG);
  assign hit_freq  = (i_cmd_code == `PWMCFG_CMD_SWITCH_FREQ);
  assign wr        = i_cmd_valid & i_cmd_write & !soft_rst_reg;
  assign rd        = i_cmd_valid & !i_cmd_write & !soft_rst_reg;

  assign cfg_code_ok  = (i_cmd_wdata[`PWMCFG_CFG_PHASE_MSB:`PWMCFG_CFG_PHASE_LSB]
                         != `PWMCFG_PHASE_CODE_UNDEFINED);
  assign freq_khz_new = lin11_value(i_cmd_wdata);
  assign freq_ok      = freq_supported(freq_khz_new);

  // voltage-range bit is left to the host to change only while off
  assign mode_accept = wr & hit_mode;
  assign cfg_accept  = wr & hit_cfg & device_off & cfg_code_ok;
  assign freq_accept = wr & hit_freq & device_off & freq_ok;
  // off-state check comes before the value check
  assign busy_refuse = wr & (hit_cfg | hit_freq) & !device_off;
  assign bad_cmd     = (wr & !(hit_reset | hit_mode | hit_cfg | hit_freq)) |
                       (wr & hit_cfg & device_off & !cfg_code_ok) |
                       (wr & hit_freq & device_off & !freq_ok) |
                       (rd & !(hit_mode | hit_cfg | hit_freq));

  assign resp_next = busy_refuse ? PWMCFG_RESP_BUSY :
                     bad_cmd     ? PWMCFG_RESP_UNSUPPORTED :
                                   PWMCFG_RESP_OK;

  // reserved bits are stored and read back untouched
  assign rdata_next = !rd       ? o_cmd_rdata :
                      hit_mode  ? {8'h00, mode_reg[i_cmd_page]} :
                      hit_cfg   ? {8'h00, cfg_reg} :
                      hit_freq  ? freq_reg : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // command answer, one cycle after the request

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd_done        <= 1'b0;
      o_cmd_resp        <= PWMCFG_RESP_OK;
      o_cmd_rdata       <= 16'h0000;
      o_busy_fault      <= 1'b0;
      o_commanded_reset <= 1'b0;
      soft_rst_reg      <= 1'b0;
    end else begin
      o_cmd_done        <= wr | rd;
      o_cmd_resp        <= (wr | rd) ? resp_next : o_cmd_resp;
      o_cmd_rdata       <= rdata_next;
      o_busy_fault      <= busy_refuse;
      o_commanded_reset <= wr & hit_reset;
      soft_rst_reg      <= wr & hit_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage; commanded reset brings back the defaults

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg[0] <= `PWMCFG_PWM_MODE_RESET;
      mode_reg[1] <= `PWMCFG_PWM_MODE_RESET;
      cfg_reg     <= `PWMCFG_PHASE_CFG_RESET;
      freq_reg    <= `PWMCFG_SWITCH_FREQ_RESET;
    end else if (soft_rst_reg) begin
      mode_reg[0] <= `PWMCFG_PWM_MODE_RESET;
      mode_reg[1] <= `PWMCFG_PWM_MODE_RESET;
      cfg_reg     <= `PWMCFG_PHASE_CFG_RESET;
      freq_reg    <= `PWMCFG_SWITCH_FREQ_RESET;
    end else begin
      if (mode_accept)
        mode_reg[i_cmd_page] <= i_cmd_wdata[7:0];
      if (cfg_accept)
        cfg_reg <= i_cmd_wdata[7:0];
      if (freq_accept)
        freq_reg <= i_cmd_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm engine controls; bits 5:2 of the mode byte feed nothing

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // ramp-on always skips pulses so the output cannot sink current
      assign o_forced_continuous[ch] =
        mode_reg[ch][`PWMCFG_MODE_CONTINUOUS_BIT] &
        !i_ramping_on[ch];
      assign o_current_range_high[ch] =
        mode_reg[ch][`PWMCFG_MODE_IRANGE_HIGH_BIT];
      assign o_voltage_range_low[ch] =
        mode_reg[ch][`PWMCFG_MODE_VRANGE_LOW_BIT];
      assign o_servo_active[ch] =
        mode_reg[ch][`PWMCFG_MODE_SERVO_BIT] & chan_running[ch] &
        !i_ramping_on[ch] & !i_ramping_off[ch];
    end
  endgenerate

  // bits 6, 5 and 3 of the shared byte feed nothing
  assign o_ea_coupled = cfg_reg[`PWMCFG_CFG_EA_COUPLE_BIT];

  pwmcfg_phase_decode u_phase_decode (
    .i_code       (cfg_reg[`PWMCFG_CFG_PHASE_MSB:`PWMCFG_CFG_PHASE_LSB]),
    .o_phase0_deg (o_phase0_deg),
    .o_phase1_deg (o_phase1_deg),
    .o_valid      ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // sync falling edge, the zero-degree reference for both phases

  logic sync_d_reg;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_reg  <= 1'b0;
      o_sync_fall <= 1'b0;
    end else begin
      sync_d_reg  <= i_sync;
      o_sync_fall <= sync_d_reg & !i_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switching frequency and pll relock

  logic [15:0] freq_khz_cur;

  assign freq_khz_cur = lin11_value(freq_reg);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_switch_freq_khz <= `PWMCFG_FREQ_350;
      o_external_osc    <= 1'b0;
      o_pll_relock      <= 1'b0;
    end else begin
      o_switch_freq_khz <= freq_khz_cur;
      o_external_osc    <= (freq_khz_cur == `PWMCFG_FREQ_EXTERNAL);
      // only a real change forces the pll to hunt again
      o_pll_relock      <= freq_accept & (i_cmd_wdata != freq_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // share clock pin

  logic vin_ok_reg;
  logic first_up_reg;
  logic share_low;

  // hysteresis latch between the turn-on and turn-off comparators
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      vin_ok_reg   <= 1'b0;
      first_up_reg <= 1'b0;
    end else begin
      if (i_vin_above_turn_on)
        vin_ok_reg <= 1'b1;
      else if (i_vin_below_turn_off)
        vin_ok_reg <= 1'b0;
      if (i_vin_above_turn_on)
        first_up_reg <= 1'b1;
    end
  end

  // with the enable clear only the first power-up holds the pin
  assign share_low = cfg_reg[`PWMCFG_CFG_SHARE_CLK_EN_BIT] ? !vin_ok_reg :
                                                             !first_up_reg;
  assign o_share_clk_out = 1'b0;
  assign o_share_clk_oe  = share_low;

endmodule // pwmcfg_top

// ===== tb/pwmcfg_props.sv
// assertion checker for the pwm engine configuration block
`timescale 1ns/1ps
`include "pwmcfg_params.svh"
module pwmcfg_props (
  // clock, reset and command port
  input wire logic                     i_clock,
  input wire logic                     i_reset_n,
  input wire logic                     i_cmd_valid,
  input wire logic                     i_cmd_write,
  input wire logic [7:0]               i_cmd_code,
  input wire pwmcfg_pkg::pwmcfg_word_t i_cmd_wdata,
  input wire logic                     o_cmd_done,
  input wire pwmcfg_pkg::pwmcfg_resp_t o_cmd_resp,
  input wire logic                     o_busy_fault,
  input wire logic                     o_commanded_reset,
  // channel state
  input wire logic [1:0]               i_run,
  input wire logic [1:0]               i_commanded_on,
  input wire logic [1:0]               i_ramping_on,
  input wire logic [1:0]               i_ramping_off,
  input wire logic                     i_sync,
  // engine controls
  input wire logic [1:0]               o_forced_continuous,
  input wire logic [1:0]               o_servo_active,
  input wire pwmcfg_pkg::pwmcfg_deg_t  o_phase0_deg,
  input wire pwmcfg_pkg::pwmcfg_deg_t  o_phase1_deg,
  input wire logic                     o_sync_fall,
  input wire logic                     o_pll_relock,
  input wire logic                     o_share_clk_out
);
  import pwmcfg_pkg::*;
  // only the single soft-reset cycle drops requests unanswered
  wire logic live = i_cmd_valid & ~o_commanded_reset;
  wire logic off = ~|(i_run & i_commanded_on);
  wire logic wcfg = live & i_cmd_write &
    (i_cmd_code == `PWMCFG_CMD_PHASE_SHARE_CFG);
  wire logic wfrq = live & i_cmd_write &
    (i_cmd_code == `PWMCFG_CMD_SWITCH_FREQ);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_guard_busy;
    (wcfg | wfrq) && !off;
  endsequence
  sequence s_bad_phase;
    wcfg && off && i_cmd_wdata[2:0] == `PWMCFG_PHASE_CODE_UNDEFINED;
  endsequence
  AST_DONE_TRACKS_REQ: assert property (
    o_cmd_done == $past(live)) else $error("done not tied to request");
  AST_BUSY_WHEN_ON: assert property (
    s_guard_busy |=> o_busy_fault && o_cmd_resp == PWMCFG_RESP_BUSY)
    else $error("write while on not refused busy");
  AST_BUSY_ONLY_CAUSE: assert property (
    o_busy_fault |-> $past((wcfg | wfrq) && !off))
    else $error("busy fault without cause");
  AST_PHASE_111_KEPT: assert property (
    s_bad_phase |=> o_cmd_resp == PWMCFG_RESP_UNSUPPORTED &&
      $stable(o_phase0_deg) && $stable(o_phase1_deg))
    else $error("phase code 111 not refused");
  AST_RAMP_DISCONT: assert property (
    (o_forced_continuous & i_ramping_on) == 2'b00)
    else $error("continuous while ramping on");
  AST_SERVO_PAUSED: assert property (
    (o_servo_active & ~(i_run & i_commanded_on & ~i_ramping_on &
      ~i_ramping_off)) == 2'b00) else $error("servo while not running");
  AST_SYNC_FALL_PULSE: assert property (
    $fell(i_sync) |=> o_sync_fall ##1 !o_sync_fall)
    else $error("sync falling edge not flagged once");
  AST_RELOCK_CAUSE: assert property (
    o_pll_relock |-> $past(wfrq && off))
    else $error("relock without accepted frequency write");
  AST_RESET_PULSE: assert property (
    live && i_cmd_write && i_cmd_code == `PWMCFG_CMD_COMMANDED_RESET
    |-> ##[1:2] o_commanded_reset) else $error("reset command lost");
  AST_SHARE_OPEN_DRAIN: assert property (
    o_share_clk_out == 1'b0) else $error("share clock driven high");
endmodule // pwmcfg_props

bind pwmcfg_top pwmcfg_props u_props (.i_clock, .i_reset_n, .i_cmd_valid,
  .i_cmd_write, .i_cmd_code, .i_cmd_wdata, .o_cmd_done, .o_cmd_resp,
  .o_busy_fault, .o_commanded_reset, .i_run, .i_commanded_on,
  .i_ramping_on, .i_ramping_off, .i_sync, .o_forced_continuous,
  .o_servo_active, .o_phase0_deg, .o_phase1_deg, .o_sync_fall,
  .o_pll_relock, .o_share_clk_out);

// ===== tb/pwmcfg_host_model.sv
// host model issuing one configuration command at a time
`timescale 1ns/1ps
module pwmcfg_host_model (
  // clock
  input  wire logic               i_clock,
  // command port toward the device
  output logic                    o_valid,
  output logic                    o_write,
  output logic [7:0]              o_code,
  output logic                    o_page,
  output pwmcfg_pkg::pwmcfg_word_t o_wdata
);
  import pwmcfg_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code = 8'h00;
    o_page = 1'b0;
    o_wdata = 16'h0000;
  end
  // one-cycle request, then one idle cycle so valid never re-asserts
  // in the step that dropped it
  task automatic send(input logic w, input logic [7:0] c, input logic p,
                      input pwmcfg_word_t d);
    o_write = w;
    o_code = c;
    o_page = p;
    o_wdata = d;
    o_valid = 1'b1;
    @(posedge i_clock);
    #1;
    o_valid = 1'b0;
    o_wdata = ~d;
    o_code = ~c;
    @(posedge i_clock);
    #1;
  endtask
endmodule // pwmcfg_host_model

// ===== tb/tb_pwmcfg_top.sv
// self-checking bench for the pwm engine configuration block
`timescale 1ns/1ps
`include "pwmcfg_params.svh"
module tb_pwmcfg_top;
  import pwmcfg_pkg::*;
  localparam logic [7:0] C_MODE = `PWMCFG_CMD_PWM_MODE;
  localparam logic [7:0] C_CFG  = `PWMCFG_CMD_PHASE_SHARE_CFG;
  localparam logic [7:0] C_FRQ  = `PWMCFG_CMD_SWITCH_FREQ;
  localparam logic [7:0] C_RST  = `PWMCFG_CMD_COMMANDED_RESET;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_sync = 1'b0;
  logic i_vin_above_turn_on = 1'b0, i_vin_below_turn_off = 1'b0;
  logic [1:0] i_run = '0, i_commanded_on = '0;
  logic [1:0] i_ramping_on = '0, i_ramping_off = '0;
  logic i_cmd_valid, i_cmd_write, i_cmd_page, o_cmd_done, o_busy_fault;
  logic o_commanded_reset, o_ea_coupled, o_sync_fall, o_external_osc;
  logic o_pll_relock, o_share_clk_out, o_share_clk_oe;
  logic [7:0] i_cmd_code;
  logic [1:0] o_forced_continuous, o_current_range_high;
  logic [1:0] o_voltage_range_low, o_servo_active;
  pwmcfg_word_t i_cmd_wdata, o_cmd_rdata, o_switch_freq_khz, rv;
  pwmcfg_resp_t o_cmd_resp;
  pwmcfg_deg_t o_phase0_deg, o_phase1_deg;
  pwmcfg_deg_t ph0 [7] = '{9'd0, 9'd90, 9'd0, 9'd0, 9'd120, 9'd60, 9'd120};
  pwmcfg_deg_t ph1 [7] = '{9'd180, 9'd270, 9'd240, 9'd120, 9'd240, 9'd240,
                           9'd300};
  pwmcfg_word_t fk [9] = '{16'd0, 16'd250, 16'd350, 16'd425, 16'd500,
                           16'd575, 16'd650, 16'd750, 16'd1000};
  logic [18:0] exp_q[$];
  logic [18:0] mon_e;
  logic [15:0] n_relock = '0, n_fall = '0, n_busy = '0;
  int err_count = 0;
  int check_count = 0;
  int seed = 19774;

  always #4 i_clock = ~i_clock;

  pwmcfg_host_model host (.i_clock, .o_valid(i_cmd_valid),
    .o_write(i_cmd_write), .o_code(i_cmd_code), .o_page(i_cmd_page),
    .o_wdata(i_cmd_wdata));

  pwmcfg_top DUT (.i_clock, .i_reset_n, .i_cmd_valid, .i_cmd_write,
    .i_cmd_code, .i_cmd_page, .i_cmd_wdata, .o_cmd_done, .o_cmd_resp,
    .o_cmd_rdata, .o_busy_fault, .o_commanded_reset, .i_run,
    .i_commanded_on, .i_ramping_on, .i_ramping_off, .i_vin_above_turn_on,
    .i_vin_below_turn_off, .i_sync, .o_forced_continuous,
    .o_current_range_high, .o_voltage_range_low, .o_servo_active,
    .o_ea_coupled, .o_phase0_deg, .o_phase1_deg, .o_sync_fall,
    .o_switch_freq_khz, .o_external_osc, .o_pll_relock, .o_share_clk_out,
    .o_share_clk_oe);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  // reads carry their expected data in d, writes their write data
  task automatic cmd(input logic w, input logic [7:0] c, input logic p,
                     input pwmcfg_word_t d, input pwmcfg_resp_t r);
    exp_q.push_back({~w, r, d});
    host.send(w, c, p, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // outputs launched on the rising edge are settled by the falling one
  always @(negedge i_clock) begin
    if (o_pll_relock === 1'b1) n_relock++;
    if (o_sync_fall === 1'b1) n_fall++;
    if (o_busy_fault === 1'b1) n_busy++;
    if (o_cmd_done === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        mon_e = exp_q.pop_front();
        chk({14'h0, o_cmd_resp}, {14'h0, mon_e[17:16]});
        if (mon_e[18]) chk(o_cmd_rdata, mon_e[15:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    $display("BAD t=%0t run hung", $time);
    conclude();
  end

  initial begin
    wt(3);
    i_reset_n = 1'b1;
    wt(3);
    cmd(0, C_MODE, 0, 16'h00C1, PWMCFG_RESP_OK);
    cmd(0, C_MODE, 1, 16'h00C1, PWMCFG_RESP_OK);
    cmd(0, C_CFG, 0, 16'h0010, PWMCFG_RESP_OK);
    cmd(0, C_FRQ, 0, 16'hFABC, PWMCFG_RESP_OK);
    chk(o_switch_freq_khz, 16'd350);
    chk({7'h0, o_phase1_deg}, 16'd180);
    chk({12'h0, o_current_range_high, o_forced_continuous}, 16'hF);
    chk({14'h0, o_voltage_range_low}, 16'h0);
    $display("test defaults done");
    for (int i = 0; i < 6; i++) begin
      rv = 16'($random(seed));
      cmd(1, C_MODE, rv[8], {8'h0, rv[7:0]}, PWMCFG_RESP_OK);
      cmd(0, C_MODE, rv[8], {8'h0, rv[7:0]}, PWMCFG_RESP_OK);
      chk({13'h0, o_forced_continuous[rv[8]], o_voltage_range_low[rv[8]],
        o_current_range_high[rv[8]]}, {13'h0, rv[0], rv[1], rv[7]});
    end
    cmd(1, C_MODE, 0, 16'h0041, PWMCFG_RESP_OK);
    cmd(1, C_MODE, 1, 16'h0041, PWMCFG_RESP_OK);
    i_run = 2'b11;
    i_commanded_on = 2'b11;
    wt(1);
    chk({14'h0, o_servo_active}, 16'h3);
    i_ramping_on = 2'b01;
    i_ramping_off = 2'b10;
    wt(1);
    chk({12'h0, o_forced_continuous, o_servo_active}, 16'h8);
    i_ramping_on = 2'b00;
    i_ramping_off = 2'b00;
    i_commanded_on = 2'b01;
    wt(1);
    chk({14'h0, o_servo_active}, 16'h1);
    $display("test mode done");
    cmd(1, C_CFG, 0, 16'h0013, PWMCFG_RESP_BUSY);
    cmd(1, C_FRQ, 0, 16'd500, PWMCFG_RESP_BUSY);
    cmd(0, C_CFG, 0, 16'h0010, PWMCFG_RESP_OK);
    chk(n_busy, 16'd2);
    i_commanded_on = 2'b00;
    for (int c = 0; c < 7; c++) begin
      cmd(1, C_CFG, 0, 16'h00E8 | 16'(c), PWMCFG_RESP_OK);
      chk({7'h0, o_phase0_deg}, {7'h0, ph0[c]});
      chk({7'h0, o_phase1_deg}, {7'h0, ph1[c]});
      chk({15'h0, o_ea_coupled}, 16'h1);
      i_sync = ~i_sync;
    end
    chk(n_fall, 16'd3);
    cmd(1, C_CFG, 0, 16'h0007, PWMCFG_RESP_UNSUPPORTED);
    cmd(0, C_CFG, 0, 16'h00EE, PWMCFG_RESP_OK);
    chk({7'h0, o_phase1_deg}, 16'd300);
    $display("test phase done");
    for (int k = 0; k < 9; k++) begin
      cmd(1, C_FRQ, 0, fk[k], PWMCFG_RESP_OK);
      chk(o_switch_freq_khz, fk[k]);
      chk({15'h0, o_external_osc}, {15'h0, fk[k] == 16'h0});
    end
    cmd(1, C_FRQ, 0, 16'h087D, PWMCFG_RESP_OK);
    chk(o_switch_freq_khz, 16'd250);
    chk(n_relock, 16'd10);
    cmd(1, C_FRQ, 0, 16'd300, PWMCFG_RESP_UNSUPPORTED);
    cmd(0, C_FRQ, 0, 16'h087D, PWMCFG_RESP_OK);
    $display("test frequency done");
    cmd(1, C_CFG, 0, 16'h0010, PWMCFG_RESP_OK);
    chk({15'h0, o_share_clk_oe}, 16'h1);
    i_vin_above_turn_on = 1'b1;
    wt(2);
    chk({15'h0, o_share_clk_oe}, 16'h0);
    i_vin_above_turn_on = 1'b0;
    i_vin_below_turn_off = 1'b1;
    wt(2);
    chk({15'h0, o_share_clk_oe}, 16'h1);
    cmd(1, C_CFG, 0, 16'h0000, PWMCFG_RESP_OK);
    chk({15'h0, o_share_clk_oe}, 16'h0);
    $display("test share clock done");
    cmd(1, C_RST, 0, 16'h0000, PWMCFG_RESP_OK);
    wt(4);
    cmd(0, C_MODE, 1, 16'h00C1, PWMCFG_RESP_OK);
    cmd(0, C_CFG, 0, 16'h0010, PWMCFG_RESP_OK);
    cmd(1, 8'h20, 0, 16'h0000, PWMCFG_RESP_UNSUPPORTED);
    $display("test reset done");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) wt(1);
    if (exp_q.size() != 0) chk(16'h0001, 16'h0000);
    conclude();
  end
endmodule // tb_pwmcfg_top
